// File: design/wdmc_consts.svh
/*
 * Constants for the watchdog and memory control block: SFR addresses, field positions, reset
 * values and watchdog timing.
 * Assumes inclusion by bare name from files under design/.
 */
`ifndef WDMC_CONSTS_SVH
`define WDMC_CONSTS_SVH

`define WDMC_ADDR_PTR0_LO 8'h82
`define WDMC_ADDR_PTR0_HI 8'h83
`define WDMC_ADDR_PTR1_LO 8'h84
`define WDMC_ADDR_PTR1_HI 8'h85
`define WDMC_ADDR_PWR_CTRL 8'h87
`define WDMC_ADDR_WD_MEM_CTRL 8'h96
`define WDMC_ADDR_SER_STATUS 8'hAA
`define WDMC_ADDR_INT_EN 8'hA8
`define WDMC_ADDR_INT_PRIO 8'hB8
`define WDMC_ADDR_SER_CTRL 8'hD5
`define WDMC_ADDR_SER_DATA 8'h86

`define WDMC_BIT_PS_HI 7
`define WDMC_BIT_PS_LO 5
`define WDMC_BIT_WR_EN 4
`define WDMC_BIT_ACC_EN 3
`define WDMC_BIT_BANK 2
`define WDMC_BIT_RESTART 1
`define WDMC_BIT_WD_EN 0
`define WDMC_BIT_PWR_OFF 4
`define WDMC_BIT_COLL 6

`define WDMC_WD_MEM_CTRL_RESET 8'h02
`define WDMC_INT_EN_RESET 8'h00
`define WDMC_INT_PRIO_RESET 8'h00
`define WDMC_SER_CTRL_RESET 8'h04
`define WDMC_PWR_CTRL_LOW_RESET 4'h0

`define WDMC_CLK_MHZ 200
`define WDMC_BASE_PERIOD_MS 16
`define WDMC_BASE_CYCLES (`WDMC_BASE_PERIOD_MS * `WDMC_CLK_MHZ * 1000)

`endif

// File: design/wdmc_pkg.sv
/*
 * Types for the watchdog and memory control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package wdmc_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdmc_sfr_req_t;

    typedef struct packed {
        logic [2:0] prescale;
        logic eeprom_write_enable;
        logic eeprom_access_enable;
        logic pointer_bank_select;
        logic watchdog_enable;
    } wdmc_ctrl_t;

    typedef enum logic [2:0] {
        WDMC_WD_OFF = 3'b001,
        WDMC_WD_RUN = 3'b010,
        WDMC_WD_FIRE = 3'b100
    } wdmc_wd_state_t;
endpackage

// File: design/wdmc_watchdog.sv
/*
 * Watchdog counter: counts base periods scaled by a 3-bit prescaler and fires a one-cycle
 * internal reset when no restart arrives in time.
 * Assumes a synchronous restart pulse and a clock enable from the register block.
 */
`timescale 1ns/1ps
`include "wdmc_consts.svh"
module wdmc_watchdog
    import wdmc_pkg::*;
#(
    parameter int BASE_CYCLES = `WDMC_BASE_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic restart,
    input wire logic [2:0] prescale,
    output logic fire
);
    // refused at elaboration: a zero base period would wrap the terminal count to all ones
    if (BASE_CYCLES < 1) begin : g_bad_base
        $error("base period must be at least one cycle");
    end

    wdmc_wd_state_t state;
    wdmc_wd_state_t next_state;
    logic [31:0] base_cnt;
    logic [31:0] next_base_cnt;
    logic [7:0] tick_cnt;
    logic [7:0] next_tick_cnt;
    logic next_fire;
    logic [7:0] tick_limit;

    // 2^prescale base periods: 16 ms up to 2048 ms
    assign tick_limit = 8'h01 << prescale;

    always_comb begin
        next_state = state;
        next_base_cnt = base_cnt;
        next_tick_cnt = tick_cnt;
        next_fire = 1'b0;
        unique case (state)
            WDMC_WD_OFF: begin
                next_base_cnt = '0;
                next_tick_cnt = '0;
                if (enable) begin
                    next_state = WDMC_WD_RUN;
                end
            end
            WDMC_WD_RUN: begin
                if (!enable) begin
                    next_state = WDMC_WD_OFF;
                end else if (restart) begin
                    next_base_cnt = '0;
                    next_tick_cnt = '0;
                end else if (base_cnt == 32'(BASE_CYCLES - 1)) begin
                    next_base_cnt = '0;
                    next_tick_cnt = tick_cnt + 8'h01;
                    if (tick_cnt + 8'h01 == tick_limit) begin
                        next_state = WDMC_WD_FIRE;
                    end
                end else begin
                    next_base_cnt = base_cnt + 32'h1;
                end
            end
            WDMC_WD_FIRE: begin
                next_fire = 1'b1;
                next_state = WDMC_WD_OFF;
            end
            default: begin
                next_state = WDMC_WD_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= WDMC_WD_OFF;
            base_cnt <= '0;
            tick_cnt <= '0;
            fire <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            base_cnt <= next_base_cnt;
            tick_cnt <= next_tick_cnt;
            fire <= next_fire;
        end
    end
endmodule

// File: design/wdmc_top.sv
/*
 * Watchdog and memory control SFR block: control register, dual data pointers, power-off
 * flag, SPI data/collision hold, interrupt enable and priority registers.
 * Assumes the CPU core issues single-cycle SFR reads and writes on core_clk, and that the
 * EEPROM array and SPI shifter report busy levels synchronous to core_clk.
 */
// Summary of operation
// - three prescale bits pick timeout, 16 ms at zero up to 2048 ms.
// - access enable steers pointer data moves to EEPROM, else external memory.
// - bank select picks data pointer bank zero or bank one.
// - writing one to restart bit pulses watchdog restart, bit self-clears.
// - restart bit is write-only; reads return EEPROM ready flag.
// - ready flag is one when idle, zero while programming runs.
// - watchdog enable bit turns the watchdog timer on or off.
// - writing SPI data during a transfer sets the write collision flag.
// - SPI data is single buffered on write and kept through reset.
// - interrupt enables in their register, SPI enable in SPI control; six priorities.
// - pointer bank zero sits at 82H-83H, bank one at 84H-85H.
// - power-off flag is bit 4 of power control, set at power-up.
// - software sets and clears power-off flag; reset leaves it alone.
`timescale 1ns/1ps
`include "wdmc_consts.svh"
module wdmc_top
    import wdmc_pkg::*;
#(
    parameter int WD_BASE_CYCLES = `WDMC_BASE_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic power_up,
    input wire wdmc_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic eeprom_busy,
    input wire logic spi_busy,
    input wire logic spi_load_done,
    output logic [15:0] data_pointer,
    output logic eeprom_select,
    output logic eeprom_write_enable,
    output logic [7:0] serial_data_reg,
    output logic serial_data_valid,
    output logic write_collision_flag,
    output logic [7:0] interrupt_enable_reg,
    output logic [7:0] interrupt_priority_reg,
    output logic spi_int_enable,
    output logic power_off_flag,
    output logic watchdog_reset
);
    wdmc_ctrl_t ctrl;
    wdmc_ctrl_t next_ctrl;
    logic restart_bit;
    logic next_restart_bit;
    localparam logic [7:0] CTRL_RST = `WDMC_WD_MEM_CTRL_RESET;
    logic [15:0] ptr0;
    logic [15:0] next_ptr0;
    logic [15:0] ptr1;
    logic [15:0] next_ptr1;
    logic [7:0] next_int_en;
    logic [7:0] next_int_prio;
    logic [7:0] ser_ctrl;
    logic [7:0] next_ser_ctrl;
    logic [3:0] pwr_ctrl_low;
    logic [3:0] next_pwr_ctrl_low;
    logic next_collision;
    logic [7:0] next_rdata;
    logic next_pwr_off;
    logic [7:0] spi_hold;
    logic [7:0] next_spi_hold;
    logic spi_hold_full;
    logic next_spi_hold_full;
    logic wd_fire;
    logic wr;
    logic [7:0] a;
    logic [7:0] d;

    assign wr = sfr_req.wr;
    assign a = sfr_req.addr;
    assign d = sfr_req.wdata;

    // reset-domain registers
    always_comb begin
        next_ctrl = ctrl;
        next_restart_bit = 1'b0;
        next_ptr0 = ptr0;
        next_ptr1 = ptr1;
        next_int_en = interrupt_enable_reg;
        next_int_prio = interrupt_priority_reg;
        next_ser_ctrl = ser_ctrl;
        next_pwr_ctrl_low = pwr_ctrl_low;
        next_collision = write_collision_flag;
        if (wr) begin
            unique case (a)
                `WDMC_ADDR_WD_MEM_CTRL: begin
                    next_ctrl.prescale = d[`WDMC_BIT_PS_HI:`WDMC_BIT_PS_LO];
                    next_ctrl.eeprom_write_enable = d[`WDMC_BIT_WR_EN];
                    next_ctrl.eeprom_access_enable = d[`WDMC_BIT_ACC_EN];
                    next_ctrl.pointer_bank_select = d[`WDMC_BIT_BANK];
                    next_ctrl.watchdog_enable = d[`WDMC_BIT_WD_EN];
                    next_restart_bit = d[`WDMC_BIT_RESTART];
                end
                `WDMC_ADDR_PTR0_LO: next_ptr0[7:0] = d;
                `WDMC_ADDR_PTR0_HI: next_ptr0[15:8] = d;
                `WDMC_ADDR_PTR1_LO: next_ptr1[7:0] = d;
                `WDMC_ADDR_PTR1_HI: next_ptr1[15:8] = d;
                `WDMC_ADDR_INT_EN: next_int_en = d;
                `WDMC_ADDR_INT_PRIO: next_int_prio = {2'b00, d[5:0]};
                `WDMC_ADDR_SER_CTRL: next_ser_ctrl = d;
                `WDMC_ADDR_PWR_CTRL: next_pwr_ctrl_low = d[3:0];
                `WDMC_ADDR_SER_STATUS: next_collision = 1'b0;
                default: begin
                end
            endcase
        end
        // set wins over the software clear
        if (wr && a == `WDMC_ADDR_SER_DATA && spi_busy) begin
            next_collision = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl <= '{prescale: CTRL_RST[`WDMC_BIT_PS_HI:`WDMC_BIT_PS_LO],
                eeprom_write_enable: CTRL_RST[`WDMC_BIT_WR_EN],
                eeprom_access_enable: CTRL_RST[`WDMC_BIT_ACC_EN],
                pointer_bank_select: CTRL_RST[`WDMC_BIT_BANK],
                watchdog_enable: CTRL_RST[`WDMC_BIT_WD_EN]};
            restart_bit <= 1'b0;
            ptr0 <= 16'h0000;
            ptr1 <= 16'h0000;
            interrupt_enable_reg <= `WDMC_INT_EN_RESET;
            interrupt_priority_reg <= `WDMC_INT_PRIO_RESET;
            ser_ctrl <= `WDMC_SER_CTRL_RESET;
            pwr_ctrl_low <= `WDMC_PWR_CTRL_LOW_RESET;
            write_collision_flag <= 1'b0;
        end else if (clk_en) begin
            ctrl <= next_ctrl;
            restart_bit <= next_restart_bit;
            ptr0 <= next_ptr0;
            ptr1 <= next_ptr1;
            interrupt_enable_reg <= next_int_en;
            interrupt_priority_reg <= next_int_prio;
            ser_ctrl <= next_ser_ctrl;
            pwr_ctrl_low <= next_pwr_ctrl_low;
            write_collision_flag <= next_collision;
        end
    end

    // state outside the reset domain: power-off flag and SPI data buffer
    always_comb begin
        next_pwr_off = power_off_flag;
        next_spi_hold = spi_hold;
        next_spi_hold_full = spi_hold_full;
        if (power_up) begin
            next_pwr_off = 1'b1;
        end else if (wr && a == `WDMC_ADDR_PWR_CTRL) begin
            next_pwr_off = d[`WDMC_BIT_PWR_OFF];
        end
        if (spi_load_done) begin
            next_spi_hold_full = 1'b0;
        end
        // collided writes are dropped so the shifting byte is not disturbed
        if (wr && a == `WDMC_ADDR_SER_DATA && !spi_busy) begin
            next_spi_hold = d;
            next_spi_hold_full = 1'b1;
        end
    end

    // no reset term here: reset must not disturb these values
    always_ff @(posedge core_clk) begin
        if (clk_en || power_up) begin
            power_off_flag <= next_pwr_off;
        end
        if (clk_en) begin
            spi_hold <= next_spi_hold;
            serial_data_reg <= next_spi_hold;
            spi_hold_full <= next_spi_hold_full;
            serial_data_valid <= next_spi_hold_full;
        end
    end

    // read mux and registered outputs
    always_comb begin
        unique case (a)
            `WDMC_ADDR_WD_MEM_CTRL: next_rdata = {ctrl.prescale, ctrl.eeprom_write_enable,
                ctrl.eeprom_access_enable, ctrl.pointer_bank_select,
                ~eeprom_busy, ctrl.watchdog_enable};
            `WDMC_ADDR_PTR0_LO: next_rdata = ptr0[7:0];
            `WDMC_ADDR_PTR0_HI: next_rdata = ptr0[15:8];
            `WDMC_ADDR_PTR1_LO: next_rdata = ptr1[7:0];
            `WDMC_ADDR_PTR1_HI: next_rdata = ptr1[15:8];
            `WDMC_ADDR_INT_EN: next_rdata = interrupt_enable_reg;
            `WDMC_ADDR_INT_PRIO: next_rdata = interrupt_priority_reg;
            `WDMC_ADDR_SER_CTRL: next_rdata = ser_ctrl;
            `WDMC_ADDR_SER_STATUS: next_rdata = {1'b0, write_collision_flag, 6'h00};
            `WDMC_ADDR_SER_DATA: next_rdata = spi_hold;
            `WDMC_ADDR_PWR_CTRL: next_rdata = {3'b000, power_off_flag, pwr_ctrl_low};
            default: next_rdata = 8'h00;
        endcase
        if (!sfr_req.rd) begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
            data_pointer <= 16'h0000;
            eeprom_select <= 1'b0;
            eeprom_write_enable <= 1'b0;
            spi_int_enable <= 1'b0;
        end else if (clk_en) begin
            sfr_rdata <= next_rdata;
            data_pointer <= next_ctrl.pointer_bank_select ? next_ptr1 : next_ptr0;
            eeprom_select <= next_ctrl.eeprom_access_enable;
            eeprom_write_enable <= next_ctrl.eeprom_write_enable;
            spi_int_enable <= next_ser_ctrl[7];
        end
    end

    wdmc_watchdog #(
        .BASE_CYCLES(WD_BASE_CYCLES)
    ) u_watchdog (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .enable(ctrl.watchdog_enable),
        .restart(restart_bit),
        .prescale(ctrl.prescale),
        .fire(wd_fire)
    );

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            watchdog_reset <= 1'b0;
        end else if (clk_en) begin
            watchdog_reset <= wd_fire;
        end
    end
endmodule

// File: verif/wdmc_monitor.sv
/* Checker for the watchdog and memory control block.
   Assumes a bind onto wdmc_top; sees only its ports. */
`timescale 1ns/1ps
module wdmc_monitor
    import wdmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic power_up,
    input wire wdmc_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic eeprom_busy,
    input wire logic spi_busy,
    input wire logic [7:0] serial_data_reg,
    input wire logic write_collision_flag,
    input wire logic power_off_flag,
    input wire logic watchdog_reset
);
    logic [3:0] off_cnt;
    logic [3:0] next_off_cnt;
    logic ctl_wr;
    logic spi_wr;
    assign ctl_wr = sfr_req.wr && clk_en && sfr_req.addr == 8'h96;
    assign spi_wr = sfr_req.wr && clk_en && sfr_req.addr == 8'h86 && spi_busy;
    // cycles since the watchdog was switched off, 0 while on
    always_comb begin
        next_off_cnt = off_cnt;
        if (ctl_wr) begin
            next_off_cnt = {3'h0, !sfr_req.wdata[0]};
        end else if (clk_en && off_cnt != 4'h0 && off_cnt != 4'hF) begin
            next_off_cnt = off_cnt + 4'h1;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            off_cnt <= 4'h1;
        end else begin
            off_cnt <= next_off_cnt;
        end
    end
    default clocking dc @(posedge core_clk); endclocking
    chk_rd_idle: assert property (disable iff (reset)
        !$past(sfr_req.rd && clk_en) |-> sfr_rdata == 8'h00) else $error("idle read not zero");
    chk_ready_flag: assert property (disable iff (reset)
        $past(sfr_req.rd && clk_en && sfr_req.addr == 8'h96) |-> sfr_rdata[1] == !$past(eeprom_busy))
        else $error("ready flag wrong");
    chk_coll_set: assert property (disable iff (reset)
        $past(spi_wr) |-> ##[0:1] write_collision_flag) else $error("collision not flagged");
    chk_spi_hold: assert property (disable iff (reset)
        $past(spi_wr) |-> $stable(serial_data_reg)) else $error("busy write changed data");
    // no disable here: the flag must ride through reset itself
    chk_pwr_off_keep: assert property (reset && $past(reset) && !$past(power_up)
        |-> $stable(power_off_flag)) else $error("reset touched power-off flag");
    chk_pwr_off_set: assert property (power_up |=> power_off_flag)
        else $error("power-up did not set flag");
    chk_wd_single: assert property (disable iff (reset)
        watchdog_reset |=> !watchdog_reset) else $error("watchdog reset too long");
    chk_wd_off: assert property (disable iff (reset)
        off_cnt > 4'h4 |-> !watchdog_reset) else $error("disabled watchdog fired");
endmodule

// File: verif/wdmc_far_model.sv
/* Far-side model: EEPROM programming and SPI shifter busy levels.
   Assumes one-cycle start strobes from the bench on core_clk. */
`timescale 1ns/1ps
module wdmc_far_model #(
    parameter int PROG_CYCLES = 6
) (
    input wire logic core_clk,
    input wire logic prog_start,
    input wire logic write_enable,
    input wire logic shift_start,
    output logic eeprom_busy,
    output logic spi_busy,
    output logic spi_load_done
);
    int prog_left = 0;
    int shift_left = 0;
    initial spi_load_done = 1'b0;
    always @(posedge core_clk) begin
        // a byte write only starts with write enable set
        if (prog_start && write_enable) prog_left <= PROG_CYCLES;
        else if (prog_left > 0) prog_left <= prog_left - 1;
        spi_load_done <= shift_start;
        if (shift_start) shift_left <= 8;
        else if (shift_left > 0) shift_left <= shift_left - 1;
    end
    assign eeprom_busy = prog_left > 0;
    assign spi_busy = shift_left > 0;
endmodule

// File: verif/tb.sv
/* Self-checking bench for the watchdog and memory control block.
   Assumes the far-side model and the checker are compiled first. */
`timescale 1ns/1ps
module tb;
    import wdmc_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic power_up = 1'b1;
    logic prog_start = 1'b0;
    logic shift_start = 1'b0;
    logic rd_taken = 1'b0;
    wdmc_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata, serial_data_reg, int_en_out, int_prio_out, v;
    logic [15:0] data_pointer;
    logic eeprom_busy, spi_busy, spi_load_done, eeprom_select, eeprom_write_enable;
    logic serial_data_valid, write_collision_flag, spi_int_enable, power_off_flag, wd_rst;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int num_checks = 0;
    int wd_hits = 0;
    int n;
    always #2.5 core_clk = ~core_clk;
    wdmc_top #(.WD_BASE_CYCLES(4)) wdmc_top_inst (.core_clk(core_clk), .reset(reset),
        .clk_en(clk_en), .power_up(power_up), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .eeprom_busy(eeprom_busy), .spi_busy(spi_busy), .spi_load_done(spi_load_done),
        .data_pointer(data_pointer), .eeprom_select(eeprom_select),
        .eeprom_write_enable(eeprom_write_enable), .serial_data_reg(serial_data_reg),
        .serial_data_valid(serial_data_valid), .write_collision_flag(write_collision_flag),
        .interrupt_enable_reg(int_en_out), .interrupt_priority_reg(int_prio_out),
        .spi_int_enable(spi_int_enable), .power_off_flag(power_off_flag),
        .watchdog_reset(wd_rst));
    wdmc_far_model wdmc_far_model_inst (.core_clk(core_clk), .prog_start(prog_start),
        .write_enable(eeprom_write_enable), .shift_start(shift_start),
        .eeprom_busy(eeprom_busy), .spi_busy(spi_busy), .spi_load_done(spi_load_done));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // the trailing idle cycles let registered effects land before checks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_req = {1'b1, 1'b0, a, d};
        @(negedge core_clk);
        sfr_req = '0;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        sfr_req = {1'b0, 1'b1, a, 8'h00};
        exp_q.push_back(e);
        @(negedge core_clk);
        sfr_req = '0;
    endtask
    always @(posedge core_clk) rd_taken <= sfr_req.rd && clk_en;
    always @(negedge core_clk) begin
        if (rd_taken) check("rdata", sfr_rdata, exp_q.pop_front());
        if (wd_rst === 1'b1) wd_hits++;
    end
    initial begin
        void'($urandom(5));
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        power_up = 1'b0;
        check("power off", power_off_flag, 1);
        rd(8'h96, 8'h02);
        rd(8'hD5, 8'h04);
        rd(8'h90, 8'h00);
        v = 8'($urandom);
        wr(8'hA8, v);
        check("int en", int_en_out, v);
        rd(8'hA8, v);
        wr(8'hB8, v);
        check("int prio", int_prio_out, v & 8'h3F);
        rd(8'hB8, v & 8'h3F);
        wr(8'hD5, v);
        check("spi int en", spi_int_enable, v[7]);
        $display("test registers done");
        for (int i = 0; i < 4; i++) wr(8'h82 + 8'(i), 8'h11 * 8'(i + 1));
        wr(8'h96, 8'h00); // bank chosen before use
        check("dp", data_pointer, 16'h2211);
        wr(8'h96, 8'h04);
        check("dp", data_pointer, 16'h4433);
        clk_en = 1'b0;
        wr(8'h84, 8'hFF);
        clk_en = 1'b1;
        check("dp", data_pointer, 16'h4433);
        rd(8'h85, 8'h44);
        rd(8'h82, 8'h11);
        $display("test pointers done");
        wr(8'h96, 8'h1A);
        check("ee", {eeprom_write_enable, eeprom_select}, 2'b11);
        prog_start = 1'b1;
        @(negedge core_clk);
        prog_start = 1'b0;
        rd(8'h96, 8'h18);
        for (n = 0; eeprom_busy === 1'b1 && n < 50; n++) @(negedge core_clk);
        if (n == 50) begin
            num_errors++;
            close_out();
        end
        rd(8'h96, 8'h1A);
        wr(8'h96, 8'h00);
        check("ee", {eeprom_write_enable, eeprom_select}, 2'b00);
        $display("test eeprom done");
        for (int p = 0; p < 8; p++) begin
            wr(8'h96, {3'(p), 5'h01});
            for (n = 0; wd_rst !== 1'b1 && n < 600; n++) @(negedge core_clk);
            if (n == 600) begin
                num_errors++;
                close_out();
            end
            check("wd", 1'(n >= (4 << p) - 3 && n <= (4 << p) + 3), 1'b1);
            wr(8'h96, 8'h00);
        end
        n = wd_hits;
        repeat (10) wr(8'h96, 8'h23);
        wr(8'h96, 8'h00);
        repeat (40) @(negedge core_clk);
        check("wd hits", 16'(wd_hits - n), 0);
        $display("test watchdog done");
        wr(8'h86, 8'hA5);
        check("spi", {serial_data_valid, serial_data_reg}, 9'h1A5);
        shift_start = 1'b1;
        @(negedge core_clk);
        shift_start = 1'b0;
        wr(8'h86, 8'h3C);
        check("coll", write_collision_flag, 1);
        check("spi", serial_data_reg, 8'hA5);
        check("spi valid", serial_data_valid, 0);
        wr(8'hAA, 8'h00);
        check("coll", write_collision_flag, 0);
        wr(8'h86, 8'h5A);
        check("spi", {serial_data_valid, serial_data_reg}, 9'h15A);
        wr(8'h87, 8'h00);
        check("power off", power_off_flag, 0);
        wr(8'h87, 8'h10);
        check("power off", power_off_flag, 1);
        reset = 1'b1;
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        check("power off", power_off_flag, 1);
        check("spi", serial_data_reg, 8'h5A);
        rd(8'h96, 8'h02);
        $display("test spi and reset done");
        repeat (2) @(negedge core_clk);
        close_out();
    end
endmodule
bind wdmc_top wdmc_monitor wdmc_monitor_inst (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .power_up(power_up), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .eeprom_busy(eeprom_busy), .spi_busy(spi_busy), .serial_data_reg(serial_data_reg),
    .write_collision_flag(write_collision_flag), .power_off_flag(power_off_flag),
    .watchdog_reset(watchdog_reset));
